// [core/pause_cfg_regs.sv]
// apb register file for pause enables, quanta and refresh intervals
// assumes a well-behaved apb master; answers with zero wait states
`timescale 1ns/1ns
module pause_cfg_regs
	import tx_pause_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire apb_req_t apb_i,
	output apb_rsp_t apb_o,
	input wire logic [31:0] status_i,
	output logic [NIDX-1:0] cfg_en,
	output logic [NIDX-1:0][QW-1:0] cfg_quanta,
	output logic [NIDX-1:0][QW-1:0] cfg_refresh
);
	typedef struct packed {
		logic [NIDX-1:0] en;
		logic [NIDX-1:0][QW-1:0] quanta;
		logic [NIDX-1:0][QW-1:0] refresh;
		apb_rsp_t rsp;
	} regs_state_t;

	regs_state_t st_q, st_d;
	logic q_hit, r_hit, wr_go;
	logic [4:0] qi, ri;

	// ==========================================================
	// decode and access
	always_comb begin
		st_d = st_q;
		qi = word_index(apb_i.paddr, ADDR_QUANTA0);
		ri = word_index(apb_i.paddr, ADDR_REFRESH0);
		q_hit = table_hit(apb_i.paddr, ADDR_QUANTA0) && (apb_i.paddr < ADDR_REFRESH0);
		r_hit = table_hit(apb_i.paddr, ADDR_REFRESH0);
		wr_go = apb_i.psel && apb_i.penable && st_q.rsp.pready && apb_i.pwrite && !st_q.rsp.pslverr;
		st_d.rsp.pready = 1'b0;
		st_d.rsp.pslverr = 1'b0;
		if (apb_i.psel && !apb_i.penable) begin
			st_d.rsp.pready = 1'b1;
			st_d.rsp.prdata = 32'h0000_0000;
			if (apb_i.paddr == ADDR_ENABLE) begin
				st_d.rsp.prdata[NIDX-1:0] = st_q.en;
			end else if (apb_i.paddr == ADDR_STATUS) begin
				st_d.rsp.prdata = status_i;
				// status is read-only, writes are refused
				st_d.rsp.pslverr = apb_i.pwrite;
			end else if (q_hit) begin
				st_d.rsp.prdata[QW-1:0] = st_q.quanta[qi[SEL_W-1:0]];
			end else if (r_hit) begin
				st_d.rsp.prdata[QW-1:0] = st_q.refresh[ri[SEL_W-1:0]];
			end else begin
				st_d.rsp.pslverr = 1'b1;
			end
		end
		if (wr_go) begin
			if (apb_i.paddr == ADDR_ENABLE) begin
				st_d.en = apb_i.pwdata[NIDX-1:0];
			end else if (q_hit) begin
				st_d.quanta[qi[SEL_W-1:0]] = apb_i.pwdata[QW-1:0];
			end else if (r_hit) begin
				st_d.refresh[ri[SEL_W-1:0]] = apb_i.pwdata[QW-1:0];
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q.en <= ENABLE_RST;
			st_q.quanta <= {NIDX{QUANTA_RST}};
			st_q.refresh <= {NIDX{REFRESH_RST}};
			st_q.rsp <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign apb_o = st_q.rsp;
	assign cfg_en = st_q.en;
	assign cfg_quanta = st_q.quanta;
	assign cfg_refresh = st_q.refresh;

	property p_quanta_write;
		@(posedge clk) disable iff (!reset_n)
		(apb_i.psel && apb_i.penable && apb_o.pready && apb_i.pwrite && apb_i.paddr == ADDR_QUANTA0)
			|=> cfg_quanta[0] == $past(apb_i.pwdata[QW-1:0]);
	endproperty
	a_quanta_write: assert property (p_quanta_write) else $error("quanta register not written");
endmodule : pause_cfg_regs

// [core/pause_refresh_timer.sv]
// one refresh timer: counts the retransmit interval after a pause frame went out
// assumes start is a one-cycle pulse and clr may be held high, both in the clk domain
`timescale 1ns/1ns
module pause_refresh_timer
	import tx_pause_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clr,
	input wire logic start,
	input wire logic [QW-1:0] interval,
	output logic expire
);
	typedef struct packed {
		logic run;
		logic [QW-1:0] cnt;
		logic exp;
	} tmr_state_t;

	tmr_state_t st_q, st_d;

	always_comb begin
		st_d = st_q;
		st_d.exp = 1'b0;
		if (clr) begin
			st_d.run = 1'b0;
			st_d.cnt = '0;
		end else if (start) begin
			// zero interval means no refresh at all
			st_d.run = (interval != '0);
			st_d.cnt = '0;
		end else if (st_q.run) begin
			if (st_q.cnt + 16'h0001 == interval) begin
				st_d.exp = 1'b1;
				st_d.run = 1'b0;
				st_d.cnt = '0;
			end else begin
				st_d.cnt = st_q.cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign expire = st_q.exp;

	property p_clr_restarts;
		@(posedge clk) disable iff (!reset_n)
		clr |=> (!st_q.run && st_q.cnt == '0 && !st_q.exp);
	endproperty
	a_clr_restarts: assert property (p_clr_restarts) else $error("timer not cleared by clr");

	property p_expire_at_interval;
		@(posedge clk) disable iff (!reset_n)
		st_q.exp |-> ($past(st_q.cnt) + 16'h0001 == $past(interval)) && $past(st_q.run);
	endproperty
	a_expire_at_interval: assert property (p_expire_at_interval) else $error("refresh expired off interval");
endmodule : pause_refresh_timer

// [core/tx_pause_pkg.sv]
// constants, carriers and helpers shared by the transmit pause control block
// assumes one clock domain and an apb master with 8-bit byte addresses
package tx_pause_pkg;
	// ==========================================================
	// sizes
	localparam int NIDX = 9;
	localparam int GLB_IDX = 8;
	localparam int QW = 16;
	localparam int SEL_W = 4;
	localparam int STAT_CNT_LSB = 16;
	localparam int STAT_OFFER_BIT = 12;

	// ==========================================================
	// register map, byte addresses
	localparam logic [7:0] ADDR_ENABLE = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_QUANTA0 = 8'h08;
	localparam logic [7:0] ADDR_REFRESH0 = 8'h30;

	// ==========================================================
	// reset values
	localparam logic [NIDX-1:0] ENABLE_RST = 9'h000;
	localparam logic [QW-1:0] QUANTA_RST = 16'h0000;
	localparam logic [QW-1:0] REFRESH_RST = 16'h0000;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic valid;
		logic global_pause;
		logic [2:0] prio;
		logic [QW-1:0] quanta;
	} tx_frame_t;

	typedef enum logic [0:0] {
		ARB_IDLE = 1'b0,
		ARB_OFFER = 1'b1
	} arb_state_t;

	// word index of addr within a table starting at base
	function automatic logic [4:0] word_index(logic [7:0] addr, logic [7:0] base);
		logic [7:0] diff;
		diff = addr - base;
		return diff[6:2];
	endfunction : word_index

	// true when addr is an aligned word inside a nine-entry table
	function automatic logic table_hit(logic [7:0] addr, logic [7:0] base);
		return (addr >= base) && (addr[1:0] == 2'h0) && (word_index(addr, base) < 5'(NIDX));
	endfunction : table_hit
endpackage : tx_pause_pkg

// [core/tx_pause_request_ctrl.sv]
// transmit pause request control: turns request bits into pause frame offers
// assumes the mac takes an offer with tx_pause_ack and flags frames in flight
// Function
// - a set request bit leads to a pause frame with that index's quanta
// - index 8 gives a global pause frame, 0 to 7 priority frames
// - each index is processed and sent only while its enable is set
// - resend makes every requested and enabled index send again after the frame in flight
// - resend also clears all retransmit counters to zero
// - quanta 8 only for global frames, 0 to 7 for matching priorities
// - enables and quanta come from registers on the bus
// - pause control inputs are active only with flow control configured
// - each index has a 16-bit refresh interval for retransmission
`timescale 1ns/1ns
module tx_pause_request_ctrl
	import tx_pause_pkg::*;
#(
	parameter bit FC_EN = 1'b1
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire apb_req_t apb_i,
	output apb_rsp_t apb_o,
	input wire logic [NIDX-1:0] pause_req,
	input wire logic resend_pause,
	input wire logic tx_data_busy,
	input wire logic tx_pause_ack,
	output tx_frame_t tx_pause_o,
	output logic [NIDX-1:0] pending_o
);
	typedef struct packed {
		arb_state_t fsm;
		logic [NIDX-1:0] req;
		logic [NIDX-1:0] pend;
		logic [SEL_W-1:0] sel;
		logic [QW-1:0] sent;
		tx_frame_t tx;
	} ctrl_state_t;

	ctrl_state_t st_q, st_d;
	logic [NIDX-1:0] cfg_en;
	logic [NIDX-1:0][QW-1:0] cfg_quanta;
	logic [NIDX-1:0][QW-1:0] cfg_refresh;
	logic [NIDX-1:0] act, rise, done_vec, start_vec, tmr_clr, expire;
	logic [31:0] status;
	logic resend;
	logic [SEL_W-1:0] pick;

	// highest index wins, so global pause goes first
	function automatic logic [SEL_W-1:0] first_set(logic [NIDX-1:0] v);
		logic [SEL_W-1:0] r;
		r = '0;
		for (int i = 0; i < NIDX; i++) begin
			if (v[i]) begin
				r = SEL_W'(i);
			end
		end
		return r;
	endfunction : first_set

	// ==========================================================
	// configuration registers
	pause_cfg_regs u_regs (
		.clk(clk),
		.reset_n(reset_n),
		.apb_i(apb_i),
		.apb_o(apb_o),
		.status_i(status),
		.cfg_en(cfg_en),
		.cfg_quanta(cfg_quanta),
		.cfg_refresh(cfg_refresh)
	);

	always_comb begin
		status = 32'h0000_0000;
		status[NIDX-1:0] = st_q.pend;
		status[STAT_OFFER_BIT] = st_q.tx.valid;
		status[STAT_CNT_LSB +: QW] = st_q.sent;
	end

	// ==========================================================
	// refresh timers, one per index
	for (genvar g = 0; g < NIDX; g++) begin : g_tmr
		pause_refresh_timer u_tmr (
			.clk(clk),
			.reset_n(reset_n),
			.clr(tmr_clr[g]),
			.start(start_vec[g]),
			.interval(cfg_refresh[g]),
			.expire(expire[g])
		);
	end

	// ==========================================================
	// request tracking and offer sequencing
	always_comb begin
		st_d = st_q;
		// without flow control every request input is ignored
		act = FC_EN ? (pause_req & cfg_en) : '0;
		resend = FC_EN && resend_pause;
		rise = act & ~st_q.req;
		done_vec = '0;
		start_vec = '0;
		pick = first_set(st_q.pend);
		st_d.req = act;
		case (st_q.fsm)
			ARB_IDLE: begin
				// wait for the frame in flight to finish
				if (st_q.pend != '0 && !tx_data_busy) begin
					st_d.sel = pick;
					st_d.tx.valid = 1'b1;
					st_d.tx.global_pause = (pick == SEL_W'(GLB_IDX));
					st_d.tx.prio = (pick == SEL_W'(GLB_IDX)) ? 3'h0 : pick[2:0];
					st_d.tx.quanta = cfg_quanta[pick];
					st_d.fsm = ARB_OFFER;
				end
			end
			ARB_OFFER: begin
				if (!act[st_q.sel]) begin
					// request or enable dropped before the mac took it
					st_d.tx.valid = 1'b0;
					st_d.fsm = ARB_IDLE;
				end else if (tx_pause_ack) begin
					st_d.tx.valid = 1'b0;
					done_vec[st_q.sel] = 1'b1;
					start_vec[st_q.sel] = 1'b1;
					st_d.sent = st_q.sent + 16'h0001;
					st_d.fsm = ARB_IDLE;
				end
			end
			default: begin
				st_d.tx.valid = 1'b0;
				st_d.fsm = ARB_IDLE;
			end
		endcase
		// a new set beats the clear from an ack in the same cycle
		st_d.pend = ((st_q.pend & ~done_vec) | rise | expire | (resend ? act : '0)) & act;
		tmr_clr = ~act | {NIDX{resend}};
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= '0;
			st_q.fsm <= ARB_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	assign tx_pause_o = st_q.tx;
	assign pending_o = st_q.pend;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	property p_req_sets_pending;
		(rise != '0) |=> ((st_q.pend & $past(rise)) == $past(rise));
	endproperty
	a_req_sets_pending: assert property (p_req_sets_pending) else $error("request did not become pending");

	property p_global_kind;
		tx_pause_o.valid |-> (tx_pause_o.global_pause == (st_q.sel == SEL_W'(GLB_IDX)));
	endproperty
	a_global_kind: assert property (p_global_kind) else $error("wrong pause frame kind");

	property p_quanta_match;
		$rose(tx_pause_o.valid) |-> tx_pause_o.quanta == $past(cfg_quanta[st_d.sel]);
	endproperty
	a_quanta_match: assert property (p_quanta_match) else $error("quanta from wrong index");

	property p_enable_gates;
		##1 ((st_q.pend & ~$past(cfg_en)) == '0);
	endproperty
	a_enable_gates: assert property (p_enable_gates) else $error("pending without enable");

	property p_resend_repends;
		resend |=> ((st_q.pend & $past(act) & act) == ($past(act) & act));
	endproperty
	a_resend_repends: assert property (p_resend_repends) else $error("resend lost a pending frame");

	property p_no_cut_in;
		$rose(tx_pause_o.valid) |-> !$past(tx_data_busy);
	endproperty
	a_no_cut_in: assert property (p_no_cut_in) else $error("offer during data frame");

	property p_no_fc_idle;
		!FC_EN |-> (st_q.pend == '0 && !tx_pause_o.valid);
	endproperty
	a_no_fc_idle: assert property (p_no_fc_idle) else $error("activity with flow control off");

	// ==========================================================
	// offer handshake checks
	// an offer may only change by ack or withdrawal, never in between
	property p_offer_stands;
		(tx_pause_o.valid && !tx_pause_ack && act[st_q.sel])
			|=> (tx_pause_o.valid && $stable(tx_pause_o));
	endproperty
	a_offer_stands: assert property (p_offer_stands) else $error("offer changed before it was taken");

	property p_ack_retires;
		(tx_pause_o.valid && tx_pause_ack && act[st_q.sel])
			|=> (!tx_pause_o.valid && st_q.sent == $past(st_q.sent) + 16'h0001);
	endproperty
	a_ack_retires: assert property (p_ack_retires) else $error("taken offer not retired");

	property p_sent_only_on_ack;
		(st_q.sent != $past(st_q.sent)) |-> $past(tx_pause_o.valid && tx_pause_ack);
	endproperty
	a_sent_only_on_ack: assert property (p_sent_only_on_ack) else $error("frame count moved without ack");

	property p_withdraw;
		(tx_pause_o.valid && !act[st_q.sel])
			|=> (!tx_pause_o.valid && !st_q.pend[$past(st_q.sel)]);
	endproperty
	a_withdraw: assert property (p_withdraw) else $error("disabled offer not withdrawn");

	property p_global_prio_zero;
		(tx_pause_o.valid && tx_pause_o.global_pause) |-> (tx_pause_o.prio == 3'h0);
	endproperty
	a_global_prio_zero: assert property (p_global_prio_zero) else $error("global frame with a priority");

	property p_prio_from_index;
		(tx_pause_o.valid && !tx_pause_o.global_pause) |-> (tx_pause_o.prio == st_q.sel[2:0]);
	endproperty
	a_prio_from_index: assert property (p_prio_from_index) else $error("priority frame for wrong index");

	// global pause has the highest index, so no priority offer may start while it is pending
	property p_highest_first;
		$rose(tx_pause_o.valid) |-> (($past(st_q.pend) >> st_q.sel) == 9'h001);
	endproperty
	a_highest_first: assert property (p_highest_first) else $error("offer skipped a higher index");

	property p_expire_repends;
		((expire & act) != '0) |=> ((st_q.pend & $past(expire & act)) == $past(expire & act));
	endproperty
	a_expire_repends: assert property (p_expire_repends) else $error("refresh expiry lost");

	property p_busy_holds_off;
		(st_q.fsm == ARB_IDLE && tx_data_busy) |=> !tx_pause_o.valid;
	endproperty
	a_busy_holds_off: assert property (p_busy_holds_off) else $error("offer raised over a data frame");
endmodule : tx_pause_request_ctrl

// [test/mac_side_model.sv]
// mac side model: takes offered pause frames, runs data frames on request
// assumes one clk domain; want_busy comes from the bench
`timescale 1ns/1ns
module mac_side_model
	import tx_pause_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic want_busy,
	input wire tx_frame_t frame_i,
	output logic tx_data_busy,
	output logic tx_pause_ack
);
	// ==========================================
	// mac handshake
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_data_busy <= 1'b0;
			tx_pause_ack <= 1'b0;
		end else begin
			// one ack per offer, never while a data frame runs
			tx_pause_ack <= frame_i.valid && !tx_pause_ack && !tx_data_busy && !want_busy;
			// data frame starts only with no offer standing
			if (!frame_i.valid) begin
				tx_data_busy <= want_busy;
			end
		end
	end
endmodule : mac_side_model

// [test/tb_tx_pause_request_ctrl.sv]
// bench for the pause request block: apb master, mac model, request stimulus
// assumes the zero wait state apb slave and the mac handshake of the block
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
$display("Error t=%0t got %0h exp %0h", $time, g, e); end end
module tb_tx_pause_request_ctrl;
	import tx_pause_pkg::*;
	logic clk, reset_n, resend, want_busy, busy, ack, er;
	apb_req_t req;
	apb_rsp_t rsp;
	tx_frame_t fr, got_q[$];
	logic [NIDX-1:0] preq, pend;
	logic [QW-1:0] qv [NIDX];
	logic [31:0] rd;
	int fail_count, cmp_count, cyc, ack_cyc, t0, ack_count, nofc_hits;
	apb_rsp_t nofc_rsp;
	tx_frame_t nofc_fr;
	logic [NIDX-1:0] nofc_pend;

	tx_pause_request_ctrl #(.FC_EN(1'b1)) dut_u (.clk(clk), .reset_n(reset_n), .apb_i(req), .apb_o(rsp),
		.pause_req(preq), .resend_pause(resend), .tx_data_busy(busy), .tx_pause_ack(ack),
		.tx_pause_o(fr), .pending_o(pend));
	mac_side_model mac_u (.clk(clk), .reset_n(reset_n), .want_busy(want_busy), .frame_i(fr),
		.tx_data_busy(busy), .tx_pause_ack(ack));
	// same stimulus into a build without flow control: it must stay silent
	tx_pause_request_ctrl #(.FC_EN(1'b0)) nofc_u (.clk(clk), .reset_n(reset_n), .apb_i(req), .apb_o(nofc_rsp),
		.pause_req(preq), .resend_pause(resend), .tx_data_busy(1'b0), .tx_pause_ack(1'b0),
		.tx_pause_o(nofc_fr), .pending_o(nofc_pend));

	// status word as the register map lays it out
	function automatic logic [31:0] status_word(input logic [NIDX-1:0] p, input logic v, input int n);
		status_word = 32'h0000_0000;
		status_word[NIDX-1:0] = p;
		status_word[STAT_OFFER_BIT] = v;
		status_word[STAT_CNT_LSB +: QW] = QW'(n);
	endfunction : status_word

	// ack to ack: interval counts, then repend, offer, ack and its sampling edge
	function automatic int refresh_gap(input int n);
		return n + 4;
	endfunction : refresh_gap

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ==========================================
	// frames taken by the mac
	always @(posedge clk) begin
		cyc++;
		if (fr.valid === 1'b1 && ack === 1'b1) begin
			got_q.push_back(fr);
			ack_cyc = cyc;
			ack_count++;
		end
		if (nofc_pend !== '0 || nofc_fr.valid !== 1'b0) begin
			nofc_hits++;
		end
	end

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 50);
		`CHK(rsp.pready, 1'b1)
		`CHK(nofc_rsp.pready, 1'b1)
		rd = rsp.prdata;
		er = rsp.pslverr;
		req <= '0;
	endtask : apb

	task expect_frame(input int i);
		int n;
		tx_frame_t f;
		n = 0;
		while (got_q.size() == 0 && n < 200) begin
			@(posedge clk);
			n++;
		end
		`CHK(got_q.size() > 0, 1'b1)
		if (got_q.size() > 0) begin
			f = got_q.pop_front();
			`CHK(f.global_pause, 1'(i == GLB_IDX))
			`CHK(f.prio, (i == GLB_IDX) ? 3'h0 : 3'(i))
			`CHK(f.quanta, qv[i])
		end
	endtask : expect_frame

	task results;
		$display("counts: %0d compared, %0d failed", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : results

	// ==========================================
	// tests
	initial begin
		req = '0;
		preq = '0;
		resend = 1'b0;
		want_busy = 1'b0;
		reset_n = 1'b0;
		rd = $urandom(20);
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		apb(0, ADDR_ENABLE, 0);
		`CHK(rd, 32'(ENABLE_RST))
		apb(0, ADDR_QUANTA0 + 8'h20, 0);
		`CHK(rd, 32'(QUANTA_RST))
		apb(0, ADDR_REFRESH0, 0);
		`CHK(rd, 32'(REFRESH_RST))
		apb(0, 8'h60, 0);
		`CHK(er, 1'b1)
		apb(1, ADDR_STATUS, 32'hFFFFFFFF);
		`CHK(er, 1'b1)
		$display("test map done");
		for (int i = 0; i < NIDX; i++) begin
			qv[i] = 16'($urandom());
			apb(1, ADDR_QUANTA0 + 8'(4 * i), {16'h0000, qv[i]});
			apb(0, ADDR_QUANTA0 + 8'(4 * i), 0);
			`CHK(rd[15:0], qv[i])
		end
		apb(1, ADDR_ENABLE, 32'h000001FF);
		// each index alone, random data frame stalls
		for (int i = 0; i < NIDX; i++) begin
			preq <= 9'(1) << i;
			want_busy <= 1'($urandom());
			repeat (3) @(posedge clk);
			want_busy <= 1'b0;
			expect_frame(i);
		end
		preq <= '0;
		$display("test single done");
		want_busy <= 1'b1;
		repeat (4) @(posedge clk);
		preq <= 9'h010;
		repeat (10) @(posedge clk);
		`CHK(fr.valid, 1'b0)
		`CHK(pend[4], 1'b1)
		apb(0, ADDR_STATUS, 0);
		`CHK(rd, status_word(9'h010, 1'b0, ack_count))
		want_busy <= 1'b0;
		expect_frame(4);
		preq <= '0;
		$display("test busy done");
		apb(1, ADDR_ENABLE, 32'h000001FB);
		preq <= 9'h004;
		repeat (20) @(posedge clk);
		`CHK(pend[2], 1'b0)
		`CHK(got_q.size(), 0)
		preq <= '0;
		apb(1, ADDR_ENABLE, 32'h000001FF);
		$display("test enable done");
		preq <= 9'h120;
		expect_frame(8);
		expect_frame(5);
		repeat (10) @(posedge clk);
		`CHK(got_q.size(), 0)
		resend <= 1'b1;
		@(posedge clk);
		resend <= 1'b0;
		expect_frame(8);
		expect_frame(5);
		preq <= '0;
		$display("test resend done");
		apb(1, ADDR_REFRESH0, 32'd20);
		preq <= 9'h001;
		expect_frame(0);
		t0 = ack_cyc;
		expect_frame(0);
		`CHK(ack_cyc - t0, refresh_gap(20))
		preq <= '0;
		$display("test refresh done");
		apb(0, ADDR_STATUS, 0);
		`CHK(rd, status_word(9'h000, 1'b0, ack_count))
		`CHK(nofc_hits, 0)
		$display("test status done");
		results();
	end

	initial begin
		#(50 * 40000);
		fail_count++;
		results();
	end
endmodule : tb_tx_pause_request_ctrl
